// *** logic/fte_ctrl.sv ***
module fte_ctrl #(
    parameter int unsigned PROG_CYCLES = fte_pkg::PROG_CYCLES
) (
    input  wire logic                 CLOCK,
    input  wire logic                 ARST_N,
    input  wire logic                 POR_N,
    input  wire fte_pkg::fte_sfr_req_t SFR_REQ,
    output fte_pkg::fte_sfr_req_t     SFR_ECHO_UNUSED_N,
    output logic [7:0]                SFR_RDATA,
    input  wire fte_pkg::fte_tbl_req_t TBL_REQ,
    output logic                      TBL_DONE,
    output fte_pkg::fte_rd_t          FLASH_RD,
    input  wire logic [15:0]          FLASH_RDATA,
    output fte_pkg::fte_prog_t        FLASH_PROG,
    output logic                      CORE_STALL,
    input  wire logic                 DONE_CLR,
    output logic                      WRITE_DONE_FLAG
);

    ////////////////////////////////////////////////////////////////////////
    // reset release
    logic [1:0] rst_sync;
    logic [1:0] por_sync;
    logic       rst_n;
    logic       por_n;

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    always_ff @(posedge CLOCK or negedge POR_N) begin
        if (!POR_N) begin
            por_sync <= 2'h0;
        end else begin
            por_sync <= {por_sync[0], 1'b1};
        end
    end

    assign rst_n = rst_sync[1];
    assign por_n = por_sync[1];

    ////////////////////////////////////////////////////////////////////////
    // states
    typedef enum logic [2:0] {
        KEY_IDLE  = 3'b001,
        KEY_GOT1  = 3'b010,
        KEY_ARMED = 3'b100
    } fte_key_t;

    typedef enum logic [4:0] {
        P_IDLE   = 5'b00001,
        P_ERASE  = 5'b00010,
        P_STREAM = 5'b00100,
        P_WAIT   = 5'b01000,
        P_FINISH = 5'b10000
    } fte_prog_st_t;

    fte_key_t             key_st;
    fte_prog_st_t         prog_st;
    logic                 space;
    logic                 cfg;
    logic                 erase_en;
    logic                 wr_err;
    logic                 write_enable_bit;
    logic                 wr;
    logic [7:0]           latch;
    logic [21:0]          ptr;
    logic [15:0]          blk;
    logic                 op_erase;
    fte_pkg::fte_target_t target;
    logic [5:0]           idx;
    logic                 rd_wait;
    logic                 timer_exp;
    logic [7:0]           hold_byte;

    logic ctrl_wr;
    logic start;
    logic tbl_take;
    assign ctrl_wr = SFR_REQ.wr && SFR_REQ.sel == fte_pkg::SEL_CTRL;
    assign start   = ctrl_wr && SFR_REQ.wdata[fte_pkg::BIT_WR]
                     && key_st == KEY_ARMED && write_enable_bit
                     && prog_st == P_IDLE;
    assign tbl_take = TBL_REQ.req && prog_st == P_IDLE
                      && !FLASH_RD.en && !rd_wait;

    assign SFR_ECHO_UNUSED_N = '0;

    ////////////////////////////////////////////////////////////////////////
    // unlock sequence: any other write breaks it
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            key_st <= KEY_IDLE;
        end else if (SFR_REQ.wr) begin
            if (SFR_REQ.sel != fte_pkg::SEL_KEY) begin
                key_st <= KEY_IDLE;
            end else if (SFR_REQ.wdata == fte_pkg::KEY_FIRST) begin
                key_st <= KEY_GOT1;
            end else if (key_st == KEY_GOT1
                         && SFR_REQ.wdata == fte_pkg::KEY_SECOND) begin
                key_st <= KEY_ARMED;
            end else begin
                key_st <= KEY_IDLE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            space    <= 1'b0;
            cfg      <= 1'b0;
            erase_en <= 1'b0;
            write_enable_bit     <= 1'b0;
        end else if (prog_st == P_FINISH) begin
            if (op_erase) begin
                erase_en <= 1'b0;
            end
        end else if (ctrl_wr && prog_st == P_IDLE) begin
            space    <= SFR_REQ.wdata[fte_pkg::BIT_SPACE];
            cfg      <= SFR_REQ.wdata[fte_pkg::BIT_CFG];
            erase_en <= SFR_REQ.wdata[fte_pkg::BIT_ERASE];
            write_enable_bit     <= SFR_REQ.wdata[fte_pkg::BIT_WRITE_ENABLE_BIT];
        end
    end

    // trigger: software can only set it, through the unlock
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            wr <= 1'b0;
        end else if (start) begin
            wr <= 1'b1;
        end else if (prog_st == P_FINISH) begin
            wr <= 1'b0;
        end
    end

    // error flag survives a plain reset so a cut-short write is traceable
    always_ff @(posedge CLOCK or negedge por_n) begin
        if (!por_n) begin
            wr_err <= 1'b0;
        end else if (start) begin
            wr_err <= 1'b1;
        end else if (prog_st == P_FINISH) begin
            wr_err <= 1'b0;
        end else if (ctrl_wr) begin
            wr_err <= SFR_REQ.wdata[fte_pkg::BIT_ERR];
        end
    end

    // set wins over a same-cycle clear
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            WRITE_DONE_FLAG <= 1'b0;
        end else if (prog_st == P_FINISH) begin
            WRITE_DONE_FLAG <= 1'b1;
        end else if (DONE_CLR) begin
            WRITE_DONE_FLAG <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // table pointer and latch
    logic [20:0] acc_low;
    logic [20:0] next_low;
    always_comb begin
        acc_low  = ptr[20:0];
        next_low = ptr[20:0];
        case (TBL_REQ.mode)
            fte_pkg::TBL_KEEP:    next_low = ptr[20:0];
            fte_pkg::TBL_POSTINC: next_low = ptr[20:0] + 21'h1;
            fte_pkg::TBL_POSTDEC: next_low = ptr[20:0] - 21'h1;
            fte_pkg::TBL_PREINC: begin
                acc_low  = ptr[20:0] + 21'h1;
                next_low = acc_low;
            end
            default:              next_low = ptr[20:0];
        endcase
    end

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            ptr <= fte_pkg::PTR_RST;
        end else if (tbl_take) begin
            ptr <= {ptr[21], next_low};
        end else if (SFR_REQ.wr) begin
            case (SFR_REQ.sel)
                fte_pkg::SEL_PTR_U: ptr[21:16] <= SFR_REQ.wdata[5:0];
                fte_pkg::SEL_PTR_H: ptr[15:8]  <= SFR_REQ.wdata;
                fte_pkg::SEL_PTR_L: ptr[7:0]   <= SFR_REQ.wdata;
                default:            ptr        <= ptr;
            endcase
        end
    end

    // read returns a word one cycle after the enable
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            FLASH_RD <= '0;
            rd_wait  <= 1'b0;
            TBL_DONE <= 1'b0;
        end else begin
            FLASH_RD.en <= tbl_take && !TBL_REQ.write;
            if (tbl_take && !TBL_REQ.write) begin
                FLASH_RD.addr <= {ptr[21], acc_low};
            end
            rd_wait  <= FLASH_RD.en;
            TBL_DONE <= rd_wait || (tbl_take && TBL_REQ.write);
        end
    end

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            latch <= fte_pkg::LATCH_RST;
        end else if (rd_wait) begin
            latch <= FLASH_RD.addr[0] ? FLASH_RDATA[15:8]
                                      : FLASH_RDATA[7:0];
        end else if (SFR_REQ.wr && SFR_REQ.sel == fte_pkg::SEL_LATCH) begin
            latch <= SFR_REQ.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // holding registers and timer
    fte_hold_buf u_hold (
        .clk       (CLOCK),
        .rst_n     (rst_n),
        .wr_en     (tbl_take && TBL_REQ.write),
        .wr_idx    (acc_low[5:0]),
        .wr_data   (latch),
        .clear_all (prog_st == P_FINISH),
        .rd_idx    (idx),
        .rd_data   (hold_byte)
    );

    fte_prog_timer #(
        .CYCLES (PROG_CYCLES)
    ) u_timer (
        .clk     (CLOCK),
        .rst_n   (rst_n),
        .start   ((prog_st == P_ERASE)
                  || (prog_st == P_STREAM && idx == fte_pkg::IDX_LAST)),
        .expired (timer_exp)
    );

    ////////////////////////////////////////////////////////////////////////
    // long write / erase sequencer
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            prog_st  <= P_IDLE;
            blk      <= 16'h0000;
            op_erase <= 1'b0;
            target   <= fte_pkg::TGT_EEPROM;
            idx      <= 6'h00;
        end else begin
            case (prog_st)
                P_IDLE: begin
                    if (start) begin
                        blk      <= ptr[21:6];
                        op_erase <= erase_en;
                        idx      <= 6'h00;
                        if (cfg) begin
                            target <= fte_pkg::TGT_CONFIG;
                        end else if (space) begin
                            target <= fte_pkg::TGT_FLASH;
                        end else begin
                            target <= fte_pkg::TGT_EEPROM;
                        end
                        prog_st <= erase_en ? P_ERASE : P_STREAM;
                    end
                end
                P_ERASE:  prog_st <= P_WAIT;
                P_STREAM: begin
                    idx <= idx + 6'h01;
                    if (idx == fte_pkg::IDX_LAST) begin
                        prog_st <= P_WAIT;
                    end
                end
                P_WAIT: begin
                    if (timer_exp) begin
                        prog_st <= P_FINISH;
                    end
                end
                P_FINISH: prog_st <= P_IDLE;
                default:  prog_st <= P_IDLE;
            endcase
        end
    end

    // only whole 64-byte rows are ever erased; ff bytes are skipped
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            FLASH_PROG <= '0;
        end else begin
            FLASH_PROG.erase <= prog_st == P_ERASE;
            FLASH_PROG.we    <= prog_st == P_STREAM
                                && hold_byte != fte_pkg::HOLD_EMPTY;
            FLASH_PROG.target <= target;
            FLASH_PROG.data   <= hold_byte;
            FLASH_PROG.addr   <= (prog_st == P_ERASE) ? {blk, 6'h00}
                                                      : {blk, idx};
        end
    end

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            CORE_STALL <= 1'b0;
        end else begin
            CORE_STALL <= start || (prog_st != P_IDLE
                                    && prog_st != P_FINISH);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read-back
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            SFR_RDATA <= 8'h00;
        end else if (SFR_REQ.rd) begin
            case (SFR_REQ.sel)
                fte_pkg::SEL_CTRL:  SFR_RDATA <= {space, cfg, 1'b0, erase_en,
                                                  wr_err, write_enable_bit, wr, 1'b0};
                fte_pkg::SEL_KEY:   SFR_RDATA <= 8'h00;
                fte_pkg::SEL_LATCH: SFR_RDATA <= latch;
                fte_pkg::SEL_PTR_U: SFR_RDATA <= {2'h0, ptr[21:16]};
                fte_pkg::SEL_PTR_H: SFR_RDATA <= ptr[15:8];
                fte_pkg::SEL_PTR_L: SFR_RDATA <= ptr[7:0];
                default:            SFR_RDATA <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!rst_n);

    chk_key_reads_zero: assert property (
        SFR_REQ.rd && SFR_REQ.sel == fte_pkg::SEL_KEY |=> SFR_RDATA == 8'h00)
        else $error("key port read not zero");

    chk_trig_needs_unlock: assert property (
        $rose(wr) |-> $past(key_st) == KEY_ARMED && $past(write_enable_bit))
        else $error("trigger accepted without unlock or enable");

    chk_err_on_trigger: assert property (
        $rose(wr) |-> wr_err)
        else $error("error flag not set with trigger");

    chk_trig_held: assert property (
        wr && prog_st != P_FINISH |=> wr)
        else $error("trigger dropped before completion");

    chk_erase_clears: assert property (
        prog_st == P_FINISH && op_erase |=> !erase_en && !wr)
        else $error("erase enable not cleared at completion");

    chk_top_bit_kept: assert property (
        tbl_take |=> ptr[21] == $past(ptr[21]))
        else $error("auto update changed pointer top bit");

    chk_core_stalled: assert property (
        $rose(wr) |=> CORE_STALL [*8])
        else $error("core not stalled during long write");

    chk_ff_skipped: assert property (
        FLASH_PROG.we |-> FLASH_PROG.data != fte_pkg::HOLD_EMPTY)
        else $error("ff byte programmed");

    chk_row_aligned: assert property (
        FLASH_PROG.erase |-> FLASH_PROG.addr[5:0] == 6'h00)
        else $error("erase address not row aligned");

    chk_done_flag: assert property (
        prog_st == P_FINISH |=> WRITE_DONE_FLAG && !wr && !wr_err)
        else $error("completion not reported");

    chk_read_done: assert property (
        tbl_take && !TBL_REQ.write |-> ##3 TBL_DONE)
        else $error("table read not done in three cycles");

    cov_erase: cover property (FLASH_PROG.erase);
    cov_write: cover property (prog_st == P_STREAM && op_erase == 1'b0);
    cov_read:  cover property (rd_wait ##1 TBL_DONE);
    cov_flag:  cover property (prog_st == P_FINISH && DONE_CLR);

endmodule // fte_ctrl

// *** logic/fte_pkg.sv ***
// What this block does
// - key port is not stored, reads zero
// - space bit picks flash or data eeprom
// - config bit overrides space, targets config
// - erase bit makes trigger erase row, self-clears
// - cycles start only with write enable; powers up clear
// - error flag set on trigger, cleared on completion
// - software sets trigger only, hardware clears it
// - write done flag sticky until software clears
// - eight bit table latch moves bytes
// - 22 bit pointer, top bit config space
// - four pointer updates per table access
// - auto update touches only low 21 bits
// - table read uses all 22 pointer bits
// - table write fills holding reg by bits 5:0
// - long write programs block from bits 21:6
// - row erase uses bits 21:6, ignores low six
// - pointer bit zero picks word byte
// - erase only whole 64 byte blocks
// - core stalls during long write, timer ends it
// - holding regs reset to ff, ff leaves byte
// - trigger after loading holding regs programs block
package fte_pkg;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned PROG_TIME_US  = 2000;
    localparam int unsigned PROG_CYCLES   =
        (PROG_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////
    // register selects on the special-function port
    localparam logic [2:0] SEL_CTRL   = 3'h0;
    localparam logic [2:0] SEL_KEY    = 3'h1;
    localparam logic [2:0] SEL_LATCH  = 3'h2;
    localparam logic [2:0] SEL_PTR_U  = 3'h3;
    localparam logic [2:0] SEL_PTR_H  = 3'h4;
    localparam logic [2:0] SEL_PTR_L  = 3'h5;

    // control register bit positions
    localparam int unsigned BIT_SPACE = 7;
    localparam int unsigned BIT_CFG   = 6;
    localparam int unsigned BIT_ERASE = 4;
    localparam int unsigned BIT_ERR   = 3;
    localparam int unsigned BIT_WRITE_ENABLE_BIT  = 2;
    localparam int unsigned BIT_WR    = 1;

    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;

    ////////////////////////////////////////////////////////////////////////
    // sizes and reset values
    localparam int unsigned PTR_W      = 22;
    localparam int unsigned LOW_W      = 21;
    localparam int unsigned HOLD_DEPTH = 64;
    localparam int unsigned IDX_W      = 6;
    localparam logic [7:0]  HOLD_EMPTY = 8'hff;
    localparam logic [7:0]  LATCH_RST  = 8'h00;
    localparam logic [21:0] PTR_RST    = 22'h000000;
    localparam logic [5:0]  IDX_LAST   = 6'h3f;

    ////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        TBL_KEEP    = 2'h0,
        TBL_POSTINC = 2'h1,
        TBL_POSTDEC = 2'h2,
        TBL_PREINC  = 2'h3
    } fte_tbl_mode_t;

    typedef enum logic [1:0] {
        TGT_EEPROM = 2'h0,
        TGT_FLASH  = 2'h1,
        TGT_CONFIG = 2'h2
    } fte_target_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] sel;
        logic [7:0] wdata;
    } fte_sfr_req_t;

    typedef struct packed {
        logic          req;
        logic          write;
        fte_tbl_mode_t mode;
    } fte_tbl_req_t;

    typedef struct packed {
        logic        en;
        logic [21:0] addr;
    } fte_rd_t;

    typedef struct packed {
        logic        we;
        logic        erase;
        fte_target_t target;
        logic [21:0] addr;
        logic [7:0]  data;
    } fte_prog_t;

endpackage

// *** logic/fte_hold_buf.sv ***
module fte_hold_buf (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       wr_en,
    input  wire logic [5:0] wr_idx,
    input  wire logic [7:0] wr_data,
    input  wire logic       clear_all,
    input  wire logic [5:0] rd_idx,
    output logic      [7:0] rd_data
);
    logic [7:0] mem [fte_pkg::HOLD_DEPTH];

    // clear wins over a same-cycle fill: the core is stalled then anyway
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < fte_pkg::HOLD_DEPTH; i++) begin
                mem[i] <= fte_pkg::HOLD_EMPTY;
            end
        end else if (clear_all) begin
            for (int i = 0; i < fte_pkg::HOLD_DEPTH; i++) begin
                mem[i] <= fte_pkg::HOLD_EMPTY;
            end
        end else if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    assign rd_data = mem[rd_idx];

endmodule // fte_hold_buf

// *** logic/fte_prog_timer.sv ***
module fte_prog_timer #(
    parameter int unsigned CYCLES = fte_pkg::PROG_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic start,
    output logic      expired
);
    localparam int unsigned W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    logic [W-1:0] cnt;
    logic         running;

    // expired pulses exactly CYCLES edges after start
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            running <= 1'b0;
            cnt     <= '0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (start) begin
                running <= 1'b1;
                cnt     <= '0;
            end else if (running) begin
                if (cnt == LAST) begin
                    running <= 1'b0;
                    expired <= 1'b1;
                end else begin
                    cnt <= cnt + 1'b1;
                end
            end
        end
    end

endmodule // fte_prog_timer

// *** verif/fte_flash_model.sv ***
module fte_flash_model (
    input  wire logic             clk,
    input  wire fte_pkg::fte_rd_t rd,
    output logic [15:0]           rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        en_q;
    logic [15:0] noise = 16'h1234;
    always_ff @(posedge clk) begin
        en_q  <= rd.en;
        noise <= noise + 16'h9e37;
    end
    // word only valid in the read slot; scrambled after, so no stale hit
    assign rdata = (rd.en || en_q) ? {rd.addr[8:1] ^ 8'h5a,
        rd.addr[16:9] ^ {rd.addr[21], 7'h00}} : noise;
endmodule // fte_flash_model

// *** verif/tb_flash_table_access_erase_control.sv ***
module tb_flash_table_access_erase_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic                  CLOCK = 1'b0, ARST_N = 1'b0, POR_N = 1'b0;
    logic                  DONE_CLR = 1'b0, TBL_DONE, CORE_STALL, WRITE_DONE_FLAG;
    fte_pkg::fte_sfr_req_t SFR_REQ = '0;
    fte_pkg::fte_tbl_req_t TBL_REQ = '0;
    fte_pkg::fte_tbl_mode_t m;
    fte_pkg::fte_rd_t      FLASH_RD;
    fte_pkg::fte_prog_t    FLASH_PROG;
    logic [15:0]           FLASH_RDATA;
    logic [7:0]            SFR_RDATA, rv, hexp [64];
    logic [21:0]           ptr, a, b;
    int fail_count = 0, checks_done = 0, cyc = 0, seed = 10464, i, n;
    initial forever #5 CLOCK = ~CLOCK;
    fte_ctrl #(.PROG_CYCLES(20)) dut (.CLOCK(CLOCK), .ARST_N(ARST_N),
        .POR_N(POR_N), .SFR_REQ(SFR_REQ), .SFR_ECHO_UNUSED_N(),
        .SFR_RDATA(SFR_RDATA), .TBL_REQ(TBL_REQ), .TBL_DONE(TBL_DONE),
        .FLASH_RD(FLASH_RD), .FLASH_RDATA(FLASH_RDATA),
        .FLASH_PROG(FLASH_PROG), .CORE_STALL(CORE_STALL),
        .DONE_CLR(DONE_CLR), .WRITE_DONE_FLAG(WRITE_DONE_FLAG));
    fte_flash_model core_side (.clk(CLOCK), .rd(FLASH_RD),
        .rdata(FLASH_RDATA));
    ////////////////////////////////////////////////////////////////////////
    task wrap_up;
        if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge CLOCK) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            wrap_up();
        end
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    endtask
    function logic [7:0] eb(input logic [21:0] p);
        return p[0] ? p[8:1] ^ 8'h5a : p[16:9] ^ {p[21], 7'h00};
    endfunction
    // auto steps wrap inside the low field, top bit carried untouched
    function logic [21:0] step(input logic [21:0] p, input logic [20:0] d);
        return {p[21], p[20:0] + d};
    endfunction
    ////////////////////////////////////////////////////////////////////////
    task wreg(input logic [2:0] s, input logic [7:0] d);
        @(negedge CLOCK) SFR_REQ = '{1'b1, 1'b0, s, d};
        @(negedge CLOCK) SFR_REQ = '0;
    endtask
    task rreg(input logic [2:0] s, output logic [7:0] v);
        @(negedge CLOCK) SFR_REQ = '{1'b0, 1'b1, s, 8'h00};
        @(negedge CLOCK) SFR_REQ = '0;
        v = SFR_RDATA;
    endtask
    task setp(input logic [21:0] p);
        wreg(3, {2'h0, p[21:16]});
        wreg(4, p[15:8]);
        wreg(5, p[7:0]);
        ptr = p;
    endtask
    task getp(output logic [21:0] p);
        logic [7:0] u, h, l;
        rreg(3, u);
        rreg(4, h);
        rreg(5, l);
        p = {u[5:0], h, l};
    endtask
    task tbl(input logic w, input fte_pkg::fte_tbl_mode_t md);
        int k;
        @(negedge CLOCK) TBL_REQ = '{1'b1, w, md};
        @(negedge CLOCK) TBL_REQ = '0;
        for (k = 0; k < 20 && TBL_DONE !== 1'b1; k++) @(negedge CLOCK);
        chk(TBL_DONE, 1'b1);
    endtask
    task load(input logic [5:0] x);
        logic [7:0] d;
        d = 8'($random(seed)) & 8'h7f;
        setp({ptr[21:6], x});
        wreg(2, d);
        tbl(1'b1, fte_pkg::TBL_KEEP);
        hexp[x] = d;
    endtask
    task automatic longop(input logic [7:0] c, input fte_pkg::fte_target_t t,
                          input int nwe, input int ner);
        int nw, ne, k;
        nw = 0;
        ne = 0;
        wreg(0, c);
        @(negedge CLOCK) DONE_CLR = 1'b1;
        @(negedge CLOCK) DONE_CLR = 1'b0;
        chk(WRITE_DONE_FLAG, 1'b0);
        wreg(1, fte_pkg::KEY_FIRST);
        wreg(1, fte_pkg::KEY_SECOND);
        wreg(0, c | 8'h02);
        for (k = 0; k < 400; k++) begin
            @(negedge CLOCK);
            if (k == 3) chk(CORE_STALL, 1'b1);
            if (FLASH_PROG.we === 1'b1) begin
                nw++;
                chk(FLASH_PROG.data, hexp[FLASH_PROG.addr[5:0]]);
            end
            if (FLASH_PROG.erase === 1'b1) ne++;
            if ((FLASH_PROG.we | FLASH_PROG.erase) === 1'b1) begin
                chk(FLASH_PROG.addr[21:6], ptr[21:6]);
                chk(FLASH_PROG.target, t);
            end
            if (k > 3 && CORE_STALL === 1'b0) break;
        end
        chk(nw, nwe);
        chk(ne, ner);
        rreg(0, rv);
        chk(rv, c & 8'hc4);
        chk(WRITE_DONE_FLAG, 1'b1);
        hexp = '{default: 8'hff};
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        hexp = '{default: 8'hff};
        repeat (20) @(negedge CLOCK);
        ARST_N = 1'b1;
        POR_N = 1'b1;
        repeat (4) @(negedge CLOCK);
        wreg(1, 8'h55);
        rreg(1, rv);
        chk(rv, 8'h00);
        rreg(0, rv);
        chk(rv[2], 1'b0);
        for (i = 0; i < 12; i++) begin
            a = 22'($random(seed));
            if (i < 3) a = (i == 0) ? 22'h1fffff : {1'b1, {21{i == 2}}};
            n = (i < 4) ? i : $random(seed);
            m = fte_pkg::fte_tbl_mode_t'(n[1:0]);
            setp(a);
            tbl(1'b0, m);
            rreg(2, rv);
            b = (m == fte_pkg::TBL_PREINC) ? step(a, 21'h1) : a;
            chk(rv, eb(b));
            getp(b);
            a = (m == fte_pkg::TBL_KEEP) ? a :
                step(a, (m == fte_pkg::TBL_POSTDEC) ? '1 : 21'h1);
            chk(b, a);
        end
        setp(22'($random(seed)));
        wreg(0, 8'h94);
        wreg(0, 8'h96);
        // keys followed by any other write no longer arm the trigger
        wreg(1, fte_pkg::KEY_FIRST);
        wreg(1, fte_pkg::KEY_SECOND);
        wreg(3, {2'h0, ptr[21:16]});
        wreg(0, 8'h96);
        rreg(0, rv);
        chk(rv, 8'h94);
        chk(CORE_STALL, 1'b0);
        longop(8'h94, fte_pkg::TGT_FLASH, 0, 1);
        @(negedge CLOCK) DONE_CLR = 1'b1;
        @(negedge CLOCK) DONE_CLR = 1'b0;
        chk(WRITE_DONE_FLAG, 1'b0);
        load(6'h00);
        load(6'h3f);
        load({1'b0, 5'($random(seed)) | 5'h01});
        longop(8'hc4, fte_pkg::TGT_CONFIG, 3, 0);
        load(6'($random(seed)));
        longop(8'h04, fte_pkg::TGT_EEPROM, 1, 0);
        // plain reset in mid-cycle must leave the error flag standing
        wreg(1, 8'h55);
        wreg(1, 8'haa);
        wreg(0, 8'h86);
        repeat (3) @(negedge CLOCK);
        ARST_N = 1'b0;
        @(negedge CLOCK) ARST_N = 1'b1;
        repeat (4) @(negedge CLOCK);
        rreg(0, rv);
        chk(rv[3], 1'b1);
        chk(rv[1], 1'b0);
        chk(CORE_STALL, 1'b0);
        wrap_up();
    end
endmodule // tb_flash_table_access_erase_control
